// file: hdl/diosd_core.sv
module diosd_core
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Digital pins
  input wire logic digital_pin_a_in,
  input wire logic digital_pin_b_in,
  output diosd_pkg::diosd_pin_t digital_pin_a,
  output diosd_pkg::diosd_pin_t digital_pin_b,
  // Sampling and alarm engine hookups
  input wire logic sample_update,
  input wire logic [15:0] alarm_control,
  input wire logic alarm_active,
  input wire logic alarm1_event,
  input wire logic alarm2_event,
  // Diagnostics hookups
  input wire logic self_test_fail,
  input wire logic rate_over_range,
  input wire logic serial_fail,
  input wire logic ctrl_update_fail,
  input wire logic supply_high,
  input wire logic supply_low,
  input wire logic flash_write,
  // Self-test controls
  output logic internal_test_en,
  output logic ext_test_neg,
  output logic ext_test_pos
);
  import diosd_pkg::*;

  // ******************************************************************
  // Link side, clocked by sclk
  // ******************************************************************
  logic [3:0] bit_cnt_reg;
  logic [14:0] rx_sh_reg;
  logic [15:0] rx_word_reg;
  logic rx_tgl_reg;
  logic [15:0] tx_sh_reg;
  logic miso_reg;
  logic [15:0] tx_word_reg;
  wire [15:0] rx_full = {rx_sh_reg, mosi};

  // Counter is cleared whenever the host deselects
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_reg <= 4'h0;
      rx_sh_reg <= 15'h0000;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      rx_sh_reg <= rx_full[14:0];
    end
  end

  // Completed frame is held and announced by a toggle
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_word_reg <= 16'h0000;
      rx_tgl_reg <= 1'b0;
    end
    else if (!cs_n && bit_cnt_reg == LAST_BIT)
    begin
      rx_word_reg <= rx_full;
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // Mode 3: first edge of a frame is falling, so the word loads there
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      tx_sh_reg <= 16'h0000;
      miso_reg <= 1'b0;
    end
    else if (bit_cnt_reg == 4'h0)
    begin
      miso_reg <= tx_word_reg[15];
      tx_sh_reg <= {tx_word_reg[14:0], 1'b0};
    end
    else
    begin
      miso_reg <= tx_sh_reg[15];
      tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
    end
  end

  assign miso = miso_reg;

  // ******************************************************************
  // Crossing into clk
  // ******************************************************************
  logic [2:0] tgl_sync_reg;
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tgl_sync_reg <= 3'h0;
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
    end
    else
    begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], rx_tgl_reg};
      pin_s1_reg <= {digital_pin_b_in, digital_pin_a_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // rx_word_reg is stable long before the toggle is seen here
  wire frame_stb = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  diosd_frame_t frame;
  assign frame = rx_word_reg;

  // ******************************************************************
  // Register decode
  // ******************************************************************
  logic [15:0] pin_cfg_reg;
  logic [15:0] misc_reg;
  logic [15:0] err_reg;
  logic [15:0] flash_cnt_reg;

  wire [5:0] word_addr = {frame.addr[5:1], 1'b0};
  wire wr_stb = frame_stb && frame.wr;
  wire rd_stb = frame_stb && !frame.wr;
  wire hit_pin = word_addr == ADDR_PIN_CFG;
  wire hit_misc = word_addr == ADDR_MISC;
  wire hit_err = word_addr == ADDR_ERR;
  wire hit_cnt = word_addr == ADDR_FLASH_CNT;
  wire [15:0] wr_lane = frame.addr[0] ? {frame.data, 8'h00}
                                      : {8'h00, frame.data};
  wire [15:0] lane_mask = frame.addr[0] ? 16'hFF00 : 16'h00FF;
  wire status_read = rd_stb && hit_err;

  wire [1:0] pin_dir = {pin_cfg_reg[PIN_DIR_A - 1],
                        pin_cfg_reg[PIN_DIR_A]};
  wire [1:0] pin_lvl = {pin_cfg_reg[PIN_LVL_A - 1],
                        pin_cfg_reg[PIN_LVL_A]};
  wire [1:0] pin_rd;
  assign pin_rd[0] = pin_dir[0] ? pin_lvl[0] : pin_s2_reg[0];
  assign pin_rd[1] = pin_dir[1] ? pin_lvl[1] : pin_s2_reg[1];
  wire [15:0] pin_cfg_rd = {6'h00, pin_dir[0], pin_dir[1],
                            6'h00, pin_rd[0], pin_rd[1]};

  logic [15:0] rd_data;
  always_comb
  begin
    if (hit_pin)
      rd_data = pin_cfg_rd;
    else if (hit_misc)
      rd_data = misc_reg;
    else if (hit_err)
      rd_data = err_reg;
    else if (hit_cnt)
      rd_data = flash_cnt_reg;
    else
      rd_data = 16'h0000;
  end

  wire [15:0] pin_cfg_next = (pin_cfg_reg & ~lane_mask) |
                             (wr_lane & MASK_PIN_CFG);
  wire [15:0] misc_next = (misc_reg & ~lane_mask) | (wr_lane & MASK_MISC);

  // Sticky flags: a new event wins over the clearing read
  wire [15:0] err_set;
  assign err_set[15:10] = 6'h00;
  assign err_set[ERR_ALARM2] = alarm2_event;
  assign err_set[ERR_ALARM1] = alarm1_event;
  assign err_set[7:6] = 2'h0;
  assign err_set[ERR_SELF_TEST] = self_test_fail;
  assign err_set[ERR_OVER_RANGE] = 1'b0;
  assign err_set[ERR_SERIAL] = serial_fail;
  assign err_set[ERR_CTRL_UPD] = ctrl_update_fail;
  assign err_set[1:0] = 2'h0;
  wire [15:0] err_hold = status_read ? 16'h0000 : err_reg;
  wire [15:0] err_live = {11'h000, rate_over_range, 2'h0,
                          supply_high, supply_low};
  wire [15:0] err_next = err_set | (err_hold & 16'h032C) | err_live;

  // ******************************************************************
  // Register storage
  // ******************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_cfg_reg <= RST_PIN_CFG;
      misc_reg <= RST_MISC;
      err_reg <= RST_ERR;
      flash_cnt_reg <= RST_FLASH_CNT;
      tx_word_reg <= 16'h0000;
    end
    else
    begin
      if (wr_stb && hit_pin)
        pin_cfg_reg <= pin_cfg_next;
      if (wr_stb && hit_misc)
        misc_reg <= misc_next;
      err_reg <= err_next;
      if (flash_write)
        flash_cnt_reg <= flash_cnt_reg + 16'h0001;
      if (rd_stb)
        tx_word_reg <= rd_data;
    end
  end

  assign internal_test_en = misc_reg[MISC_INT_TEST];
  assign ext_test_neg = misc_reg[MISC_EXT_NEG];
  assign ext_test_pos = misc_reg[MISC_EXT_POS];

  // ******************************************************************
  // Pin drivers
  // ******************************************************************
  logic drdy_reg;
  diosd_pin_t pin_reg [2];
  diosd_pin_t pin_next [2];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      drdy_reg <= 1'b0;
    else
      drdy_reg <= sample_update;
  end

  wire drdy_lvl = misc_reg[DRDY_POL] ? drdy_reg : ~drdy_reg;
  wire alm_lvl = alarm_control[ALM_POL] ? alarm_active : ~alarm_active;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_line
      wire drdy_here = misc_reg[DRDY_EN] &&
                       misc_reg[DRDY_SEL] == 1'(i);
      wire alm_here = alarm_control[ALM_EN] &&
                      alarm_control[ALM_SEL] == 1'(i);
      always_comb
      begin
        if (pin_dir[i])
          pin_next[i] = '{level: pin_lvl[i], oe: 1'b1};
        else if (drdy_here)
          pin_next[i] = '{level: drdy_lvl, oe: 1'b1};
        else if (alm_here)
          pin_next[i] = '{level: alm_lvl, oe: 1'b1};
        else
          pin_next[i] = '{level: 1'b0, oe: 1'b0};
      end
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          pin_reg[i] <= '{level: 1'b0, oe: 1'b0};
        else
          pin_reg[i] <= pin_next[i];
      end
    end
  endgenerate

  assign digital_pin_a = pin_reg[0];
  assign digital_pin_b = pin_reg[1];

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_drdy_a_owned;
    !pin_dir[0] && misc_reg[DRDY_EN] && !misc_reg[DRDY_SEL];
  endsequence

  sequence s_drdy_fire_a;
    (sample_update && !pin_dir[0] && misc_reg[DRDY_EN] &&
      !misc_reg[DRDY_SEL]) ##1 s_drdy_a_owned;
  endsequence

  AST_GP_OUT_DRIVES:
    assert property (pin_dir[0] |=> digital_pin_a.oe &&
      digital_pin_a.level == $past(pin_lvl[0]))
    else $error("line 0 output does not follow its level bit");

  AST_GP_IN_RELEASED:
    assert property (!pin_dir[1] && !(misc_reg[DRDY_EN] &&
      misc_reg[DRDY_SEL]) && !(alarm_control[ALM_EN] &&
      alarm_control[ALM_SEL]) |=> !digital_pin_b.oe)
    else $error("line 1 driven while unclaimed input");

  AST_PIN_READBACK:
    assert property (!pin_dir[1] |-> pin_cfg_rd[0] == pin_s2_reg[1])
    else $error("input line 1 level not visible");

  AST_DRDY_PULSE:
    assert property (s_drdy_fire_a |=> digital_pin_a.oe &&
      digital_pin_a.level == $past(misc_reg[DRDY_POL]))
    else $error("data-ready not shown on line 0");

  AST_DRDY_OVER_ALARM:
    assert property (s_drdy_a_owned and (alarm_control[ALM_EN] &&
      !alarm_control[ALM_SEL] && !drdy_reg) |=>
      digital_pin_a.level == !$past(misc_reg[DRDY_POL]))
    else $error("alarm took a line owned by data-ready");

  AST_SELF_TEST_FLAG:
    assert property (self_test_fail |=> err_reg[ERR_SELF_TEST] [*2]
      or (err_reg[ERR_SELF_TEST] ##1 $past(status_read)))
    else $error("self-test failure not latched");

  AST_STICKY_HOLD:
    assert property (err_reg[ERR_SERIAL] && !status_read |=>
      err_reg[ERR_SERIAL])
    else $error("serial failure flag lost without a read");

  AST_READ_CLEARS:
    assert property (status_read && err_set == 16'h0000 |=>
      (err_reg & 16'h032C) == 16'h0000)
    else $error("status read left a sticky flag set");

  AST_SUPPLY_FOLLOWS:
    assert property (err_reg[ERR_SUPPLY_LOW] && !supply_low |=>
      !err_reg[ERR_SUPPLY_LOW])
    else $error("supply low flag did not self clear");

  AST_FLASH_COUNT:
    assert property (flash_write |=>
      flash_cnt_reg == $past(flash_cnt_reg) + 16'h0001)
    else $error("flash write not counted");

  AST_MISC_WRITE:
    assert property (wr_stb && hit_misc && !frame.addr[0] |=>
      misc_reg[7:0] == ($past(frame.data) & MASK_MISC[7:0]))
    else $error("misc control low byte write lost");

endmodule : diosd_core

// file: hdl/diosd_pkg.sv
package diosd_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [5:0] ADDR_FLASH_CNT = 6'h00;
  localparam logic [5:0] ADDR_PIN_CFG = 6'h32;
  localparam logic [5:0] ADDR_MISC = 6'h34;
  localparam logic [5:0] ADDR_ERR = 6'h3C;

  localparam logic [15:0] RST_PIN_CFG = 16'h0000;
  localparam logic [15:0] RST_MISC = 16'h0000;
  localparam logic [15:0] RST_ERR = 16'h0000;
  localparam logic [15:0] RST_FLASH_CNT = 16'h0000;
  localparam logic [15:0] MASK_PIN_CFG = 16'h0303;
  localparam logic [15:0] MASK_MISC = 16'h0707;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int PIN_DIR_A = 9;
  localparam int PIN_LVL_A = 1;
  localparam int MISC_INT_TEST = 10;
  localparam int MISC_EXT_NEG = 9;
  localparam int MISC_EXT_POS = 8;
  localparam int DRDY_EN = 2;
  localparam int DRDY_POL = 1;
  localparam int DRDY_SEL = 0;
  localparam int ALM_EN = 2;
  localparam int ALM_POL = 1;
  localparam int ALM_SEL = 0;
  localparam int ERR_ALARM2 = 9;
  localparam int ERR_ALARM1 = 8;
  localparam int ERR_SELF_TEST = 5;
  localparam int ERR_OVER_RANGE = 4;
  localparam int ERR_SERIAL = 3;
  localparam int ERR_CTRL_UPD = 2;
  localparam int ERR_SUPPLY_HIGH = 1;
  localparam int ERR_SUPPLY_LOW = 0;

  // ******************************************************************
  // Serial frame
  // ******************************************************************
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] LAST_BIT = 4'hF;

  typedef struct packed {
    logic wr;
    logic spare;
    logic [5:0] addr;
    logic [7:0] data;
  } diosd_frame_t;

  typedef struct packed {
    logic level;
    logic oe;
  } diosd_pin_t;

endpackage : diosd_pkg

// file: tb/diosd_host_model.sv
module diosd_host_model
(
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b0;
    mosi = 1'b0;
    // Real rising edge of the select clears the link-side counter
    #1;
    cs_n = 1'b1;
  end

  // Mode 3, MSB first; the clock stands high between frames
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    #5;
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = tx[i];
      #3;
      sclk = 1'b1;
      rx[i] = miso;
      #3;
    end
    #5;
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask : frame
endmodule : diosd_host_model

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import diosd_pkg::*;

  typedef struct packed {
    logic [15:0] cfg;
    logic a_in;
    logic b_in;
    logic [15:0] rd;
    logic [3:0] pins;
  } diosd_row_t;

  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic sclk, cs_n, mosi, miso;
  logic pin_a_in, pin_b_in, sample_update, alarm_active, flash_write;
  logic alarm1_event, alarm2_event, self_test_fail, serial_fail;
  logic ctrl_update_fail, rate_over_range, supply_high, supply_low;
  logic [15:0] alarm_control;
  diosd_pin_t pin_a, pin_b;
  logic int_test, ext_neg, ext_pos;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  diosd_row_t rows [6] = '{
    '{16'h0202, 1'b0, 1'b1, 16'h0203, 4'b1100},
    '{16'h0000, 1'b1, 1'b0, 16'h0002, 4'b0000},
    '{16'h0101, 1'b0, 1'b1, 16'h0101, 4'b0011},
    '{16'h0300, 1'b1, 1'b1, 16'h0300, 4'b1010},
    '{16'hFFFF, 1'b0, 1'b0, 16'h0303, 4'b1111},
    '{16'h0302, 1'b1, 1'b0, 16'h0302, 4'b1110}};

  always #25 clk = ~clk;

  diosd_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));

  diosd_core dut_u (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .digital_pin_a_in(pin_a_in),
    .digital_pin_b_in(pin_b_in), .digital_pin_a(pin_a),
    .digital_pin_b(pin_b), .sample_update(sample_update),
    .alarm_control(alarm_control), .alarm_active(alarm_active),
    .alarm1_event(alarm1_event), .alarm2_event(alarm2_event),
    .self_test_fail(self_test_fail), .rate_over_range(rate_over_range),
    .serial_fail(serial_fail), .ctrl_update_fail(ctrl_update_fail),
    .supply_high(supply_high), .supply_low(supply_low),
    .flash_write(flash_write), .internal_test_en(int_test),
    .ext_test_neg(ext_neg), .ext_test_pos(ext_pos));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    host_u.frame(tx, rx);
    repeat (8) @(negedge clk);
  endtask : xfer

  // High byte goes to the odd address, low byte to the even one
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    logic [15:0] rx;
    xfer({2'b10, a | 6'h01, v[15:8]}, rx);
    xfer({2'b10, a & 6'h3E, v[7:0]}, rx);
  endtask : wr16

  // Read data returns in the following frame
  task automatic rdchk(input string name, input logic [5:0] a,
    input logic [15:0] exp);
    logic [15:0] rx;
    xfer({2'b00, a, 8'h00}, rx);
    xfer({2'b00, 6'h3E, 8'h00}, rx);
    check(name, rx, exp);
  endtask : rdchk

  task automatic pinchk(input logic [3:0] exp);
    check("pins", {12'h000, pin_a.oe, pin_a.oe & pin_a.level, pin_b.oe,
      pin_b.oe & pin_b.level}, {12'h000, exp});
  endtask : pinchk

  // Counts cycles where the selected pin shows the wanted level
  task automatic drdy_count(input logic sel, want, output int cnt);
    cnt = 0;
    sample_update = 1'b1;
    @(negedge clk);
    sample_update = 1'b0;
    repeat (6)
    begin
      @(negedge clk);
      if ((sel ? pin_b.level : pin_a.level) === want)
        cnt++;
    end
  endtask : drdy_count

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      complete_run();
    end
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    {pin_a_in, pin_b_in, sample_update, alarm_active, flash_write} = '0;
    {alarm1_event, alarm2_event, self_test_fail, serial_fail} = '0;
    {ctrl_update_fail, rate_over_range, supply_high, supply_low} = '0;
    alarm_control = 16'h0000;
    // Real rising edge so the link-side reset takes effect
    #1;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    pinchk(4'b0000);
    rdchk("pin_config", ADDR_PIN_CFG, 16'h0000);
    rdchk("misc_control", ADDR_MISC, 16'h0000);
    rdchk("error_flags", ADDR_ERR, 16'h0000);
    rdchk("flash_cnt", ADDR_FLASH_CNT, 16'h0000);
    foreach (rows[i])
    begin
      pin_a_in = rows[i].a_in;
      pin_b_in = rows[i].b_in;
      wr16(ADDR_PIN_CFG, rows[i].cfg);
      rdchk("pin_config", ADDR_PIN_CFG, rows[i].rd);
      pinchk(rows[i].pins);
    end
    wr16(ADDR_MISC, 16'hFFFF);
    rdchk("misc_control", ADDR_MISC, 16'h0707);
    check("tests", {13'h0, int_test, ext_neg, ext_pos}, 16'h0007);
    wr16(ADDR_MISC, 16'h0400);
    check("tests", {13'h0, int_test, ext_neg, ext_pos}, 16'h0004);
    wr16(ADDR_PIN_CFG, 16'h0000);
    wr16(ADDR_MISC, 16'h0006);
    drdy_count(1'b0, 1'b1, n);
    check("drdy_a_high", 16'(n), 16'h0001);
    check("drdy_a_oe", {15'h0, pin_a.oe}, 16'h0001);
    wr16(ADDR_MISC, 16'h0005);
    drdy_count(1'b1, 1'b0, n);
    check("drdy_b_low", 16'(n), 16'h0001);
    wr16(ADDR_PIN_CFG, 16'h0100);
    wr16(ADDR_MISC, 16'h0007);
    drdy_count(1'b1, 1'b1, n);
    check("gp_over_drdy", 16'(n), 16'h0000);
    wr16(ADDR_PIN_CFG, 16'h0000);
    alarm_control = 16'h0006;
    alarm_active = 1'b1;
    repeat (4) @(negedge clk);
    pinchk(4'b1110);
    alarm_control = 16'h0002;
    repeat (4) @(negedge clk);
    pinchk(4'b0010);
    alarm_control = 16'h0006;
    wr16(ADDR_MISC, 16'h0006);
    pinchk(4'b1000);
    alarm_active = 1'b0;
    {rate_over_range, supply_high, supply_low} = 3'b111;
    {alarm1_event, alarm2_event, self_test_fail} = 3'b111;
    {serial_fail, ctrl_update_fail} = 2'b11;
    @(negedge clk);
    {alarm1_event, alarm2_event, self_test_fail} = 3'b000;
    {serial_fail, ctrl_update_fail} = 2'b00;
    rdchk("error_flags", ADDR_ERR, 16'h033F);
    rdchk("error_flags", ADDR_ERR, 16'h0013);
    {rate_over_range, supply_high, supply_low} = 3'b000;
    rdchk("error_flags", ADDR_ERR, 16'h0000);
    rdchk("unmapped", 6'h3E, 16'h0000);
    repeat (3)
    begin
      flash_write = 1'b1;
      @(negedge clk);
      flash_write = 1'b0;
      @(negedge clk);
    end
    rdchk("flash_cnt", ADDR_FLASH_CNT, 16'h0003);
    wr16(ADDR_FLASH_CNT, 16'h1234);
    rdchk("flash_cnt", ADDR_FLASH_CNT, 16'h0003);
    complete_run();
  end
endmodule : tb
